// ---- rtl/rudl_decode.sv ----
// Function and range decode from the latched control word
`timescale 1ns/1ns
module rudl_decode (
   input  wire logic [rudl_pkg::CTRL_W-1:0] ctrl_i,
   output logic      [rudl_pkg::NDRV-1:0]   latch_val_o,
   output logic      [rudl_pkg::NHELD-1:0]  held_val_o
);
   import rudl_pkg::*;

   // ==========================================================
   // Function decode
   wire                i_sel     = ~ctrl_i[F_I_N];
   wire                o_sel     = ~ctrl_i[F_O_N];
   wire                volt_mode = ctrl_i[F_I_N] & ctrl_i[F_O_N];
   wire                off       = ctrl_i[F_OFF];
   wire                watchdog_a      = ctrl_i[F_WATCHDOG_A];
   wire                zero      = ctrl_i[F_ZERO];
   wire [CODE_W-1:0]   or_code   = ctrl_i[F_OR_LO +: CODE_W];
   // Voltage mode forces the all-ones current code
   wire [CODE_W-1:0]   ir_code   = volt_mode ? IR_VOLT : ctrl_i[F_IR_LO +: CODE_W];
   wire [N_CODES-1:0]  cur_q;
   wire [N_CODES-1:0]  ohm_q;
   wire                iso_close;

   // ==========================================================
   // Range decoders
   genvar k;
   generate
      for (k = 0; k < N_CODES; k++) begin : g_dec
         assign cur_q[k] = (ir_code == CODE_W'(k));
         assign ohm_q[k] = (or_code == CODE_W'(k)) & o_sel & ~zero;
      end
   endgenerate

   // Isolation relay closes on logic 0, the reverse of the others
   assign iso_close = ~o_sel | ~or_code[CODE_W-1] | zero | ohm_q[Q_100K];

   // ==========================================================
   // Latching driver values, logic 1 selects
   assign latch_val_o[DRV_HIRNG]  = cur_q[Q_1A];
   assign latch_val_o[DRV_VOLT]   = volt_mode;
   assign latch_val_o[DRV_ISO]    = ~iso_close;
   assign latch_val_o[DRV_DCREF]  = i_sel & ~watchdog_a & ctrl_i[F_DCI];
   assign latch_val_o[DRV_ACREF]  = i_sel & ~watchdog_a & ~ctrl_i[F_DCI];
   assign latch_val_o[DRV_ZERO]   = zero | ~o_sel;
   assign latch_val_o[DRV_SPARE0] = 1'b0;
   assign latch_val_o[DRV_SPARE1] = 1'b0;
   assign latch_val_o[DRV_OHM_LO +: N_CODES] = ohm_q;

   // ==========================================================
   // Held relays
   assign held_val_o[H_R100M]  = cur_q[Q_100M];
   assign held_val_o[H_R10M]   = cur_q[Q_10M];
   assign held_val_o[H_R1M]    = cur_q[Q_1M];
   assign held_val_o[H_FILT]   = volt_mode | cur_q[Q_100M] | cur_q[Q_10M];
   assign held_val_o[H_IOUT_A] = ~off & i_sel;
   assign held_val_o[H_IOUT_B] = ~off & i_sel;
   assign held_val_o[H_OOUT_A] = ~off & o_sel & ~watchdog_a;
   assign held_val_o[H_OOUT_B] = ~off & o_sel & ~watchdog_a;
   assign held_val_o[H_ACV]    = volt_mode & ~ctrl_i[F_AC_N];
   assign held_val_o[H_ACIREF] = i_sel;
endmodule

// ---- rtl/rudl_pkg.sv ----
// Constants, register map and types for the relay update drive logic
package rudl_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ       = 25_000_000;
   localparam int unsigned PULSE_MS     = 50;
   localparam int unsigned MS_PER_S     = 1000;
   localparam int unsigned PULSE_CYCLES = PULSE_MS * (CLK_HZ / MS_PER_S);
   localparam int          CNT_W        = 21;

   // ==========================================================
   // Register map (byte addresses)
   localparam int          ADR_W     = 8;
   localparam logic [7:0]  ADR_CTRL  = 8'h00;
   localparam logic [7:0]  ADR_CMD   = 8'h04;
   localparam logic [7:0]  ADR_STAT  = 8'h08;
   localparam logic [7:0]  ADR_LATCH = 8'h0C;

   // ==========================================================
   // Control word fields (1 = 0V level, 0 = -15V level)
   localparam int          CTRL_W   = 16;
   localparam int          F_I_N    = 0;
   localparam int          F_O_N    = 1;
   localparam int          F_DCI    = 2;
   localparam int          F_AC_N   = 3;
   localparam int          F_OFF    = 4;
   localparam int          F_WATCHDOG_A   = 5;
   localparam int          F_ZERO   = 6;
   localparam int          F_IR_LO  = 8;
   localparam int          F_OR_LO  = 12;
   localparam int          CODE_W   = 3;
   localparam int          N_CODES  = 8;
   localparam logic [15:0] CTRL_RST = 16'h071B;
   localparam logic [2:0]  IR_VOLT  = 3'h7;

   // ==========================================================
   // Command and status bits
   localparam int          CMD_GO  = 0;
   localparam int          ST_BUSY = 0;
   localparam int          ST_PEND = 1;

   // ==========================================================
   // Latching drivers: 16 buffers, groups of four
   localparam int NDRV       = 16;
   localparam int GRP_SZ     = 4;
   localparam int NGRP       = 4;
   localparam int DRV_HIRNG  = 0;
   localparam int DRV_VOLT   = 1;
   localparam int DRV_ISO    = 2;
   localparam int DRV_DCREF  = 3;
   localparam int DRV_ACREF  = 4;
   localparam int DRV_ZERO   = 5;
   localparam int DRV_SPARE0 = 6;
   localparam int DRV_SPARE1 = 7;
   localparam int DRV_OHM_LO = 8;

   // ==========================================================
   // Held (non-latching) relay lines
   localparam int NHELD     = 10;
   localparam int H_R100M   = 0;
   localparam int H_R10M    = 1;
   localparam int H_R1M     = 2;
   localparam int H_FILT    = 3;
   localparam int H_IOUT_A  = 4;
   localparam int H_IOUT_B  = 5;
   localparam int H_OOUT_A  = 6;
   localparam int H_OOUT_B  = 7;
   localparam int H_ACV     = 8;
   localparam int H_ACIREF  = 9;

   // Current and ohms range decoder outputs used
   localparam int Q_1A    = 2;
   localparam int Q_100M  = 3;
   localparam int Q_10M   = 4;
   localparam int Q_1M    = 5;
   localparam int Q_100K  = 4;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_XFER   = 2'b01,
      ST_SETTLE = 2'b10,
      ST_PULSE  = 2'b11
   } rudl_state_t;

endpackage

// ---- rtl/rudl_top.sv ----
// Relay update drive logic: Wishbone registers, transfer and update pulse
`timescale 1ns/1ns
// Functional notes
// - Each command, or one merged group of commands made while busy, transfers control bits, then drives the strobe low for 50 ms.
// - Logic 0 means -15V and logic 1 means 0V on every control line.
// - Control bits stay latched between transfers.
// - Latching drivers drive only during the strobe, else high impedance.
// - Driver at 1 during update selects the relay, 0 deselects.
// - Low-range isolation relay driver at 0 selects lower resistance ranges.
// - Output relays are held levels, changed at the update pulse.
// - Strobe buffered once, then enables four groups of four drivers.
// - Current pair selects current, ohms pair selects ohms, voltage relay voltage.
// - Both function selects at 1 drive the voltage relay selected.
// - Voltage mode uses current range code all ones, only output seven.
// - Voltage mode latches high range relay off-1A, filter relay connected.
// - Current select at 1 forces both current reference relays off.
// - AC select connects voltage lines only in voltage mode; AC current ref line follows current select.
// - Ohms range code in ohms mode without zero gives one-hot range selects.
// - Function encoding of select, DC-current and AC bits as tabulated.
// - Current output relays need output on and current selected.
// - Ohms output relays need ohms selected, output on, no watchdog watchdog_a.
// - Ohms range is a three-bit code, eight ranges low to high.
module rudl_top #(
   parameter int unsigned P_PULSE_CYCLES = rudl_pkg::PULSE_CYCLES
) (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [rudl_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [3:0]                    wb_sel_i,
   input  wire logic [31:0]                   wb_dat_i,
   output logic      [31:0]                   wb_dat_o,
   output logic                               wb_ack_o,
   output logic                               relay_update_strobe_n_o,
   output logic      [rudl_pkg::NGRP-1:0]     drv_group_en_n_o,
   output logic      [rudl_pkg::NDRV-1:0]     latch_drv_o,
   output logic      [rudl_pkg::NDRV-1:0]     latch_drv_oe_o,
   output logic      [rudl_pkg::NHELD-1:0]    held_relay_o,
   output logic      [rudl_pkg::CTRL_W-1:0]   control_latched_o
);
   import rudl_pkg::*;

   // ==========================================================
   // Declarations
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(P_PULSE_CYCLES - 1);

   rudl_state_t         state_r;
   rudl_state_t         state_nxt;
   logic [CNT_W-1:0]    cnt_r;
   logic [CNT_W-1:0]    cnt_nxt;
   logic [CTRL_W-1:0]   staged_r;
   logic [CTRL_W-1:0]   latched_r;
   logic                pend_r;
   logic                ack_r;
   logic [31:0]         dat_r;
   logic                strobe_n_r;
   logic [NGRP-1:0]     grp_en_n_r;
   logic [NDRV-1:0]     drv_r;
   logic [NDRV-1:0]     oe_r;
   logic [NHELD-1:0]    held_r;
   logic [NDRV-1:0]     latch_val;
   logic [NHELD-1:0]    held_val;

   // ==========================================================
   // Bus decode
   wire                 req      = wb_cyc_i & wb_stb_i & ~ack_r;
   wire                 wr       = req & wb_we_i;
   wire                 hit_ctrl = (wb_adr_i == ADR_CTRL);
   wire                 hit_cmd  = (wb_adr_i == ADR_CMD);
   wire                 hit_stat = (wb_adr_i == ADR_STAT);
   wire                 hit_lat  = (wb_adr_i == ADR_LATCH);
   wire                 wr_ctrl  = wr & hit_ctrl;
   wire                 go_req   = wr & hit_cmd & wb_sel_i[0] & wb_dat_i[CMD_GO];
   wire                 busy     = (state_r != ST_IDLE);
   wire                 pulse_nx = (state_nxt == ST_PULSE);
   wire                 pend_nxt = busy & (go_req | pend_r);
   wire [CTRL_W-1:0]    ctrl_wr  = {wb_sel_i[1] ? wb_dat_i[15:8] : staged_r[15:8],
                                    wb_sel_i[0] ? wb_dat_i[7:0]  : staged_r[7:0]};
   wire [31:0]          stat_wd  = {30'h0, pend_r, busy};
   wire [31:0]          rd_mux   = hit_ctrl ? {16'h0, staged_r}  :
                                   hit_stat ? stat_wd            :
                                   hit_lat  ? {16'h0, latched_r} : 32'h0;

   // ==========================================================
   // Registers seen by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r    <= 1'b0;
         dat_r    <= 32'h0;
         staged_r <= CTRL_RST;
         pend_r   <= 1'b0;
      end else begin
         ack_r    <= req;
         dat_r    <= (req & ~wb_we_i) ? rd_mux : 32'h0;
         pend_r   <= pend_nxt;
         if (wr_ctrl) begin
            staged_r <= ctrl_wr;
         end
      end
   end

   // ==========================================================
   // Decode of the latched word
   rudl_decode i_rudl_decode (
      .ctrl_i      (latched_r),
      .latch_val_o (latch_val),
      .held_val_o  (held_val)
   );

   // ==========================================================
   // Transfer and update sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE: begin
            if (go_req | pend_r) begin
               state_nxt = ST_XFER;
            end
         end
         ST_XFER: begin
            state_nxt = ST_SETTLE;
         end
         ST_SETTLE: begin
            state_nxt = ST_PULSE;
            cnt_nxt   = '0;
         end
         ST_PULSE: begin
            if (cnt_r == CNT_LAST) begin
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r   <= ST_IDLE;
         cnt_r     <= '0;
         latched_r <= CTRL_RST;
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         if (state_r == ST_XFER) begin
            latched_r <= staged_r;
         end
      end
   end

   // ==========================================================
   // Strobe, group enables and held relays
   // Enables come from the same edge as the strobe, so no driver leads it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_n_r <= 1'b1;
         grp_en_n_r <= '1;
         held_r     <= '0;
      end else begin
         strobe_n_r <= ~pulse_nx;
         grp_en_n_r <= {NGRP{~pulse_nx}};
         if (pulse_nx & (state_r == ST_SETTLE)) begin
            held_r <= held_val;
         end
      end
   end

   // ==========================================================
   // Tristate latching drivers, one per buffer
   genvar i;
   generate
      for (i = 0; i < NDRV; i++) begin : g_drv
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               oe_r[i]  <= 1'b0;
               drv_r[i] <= 1'b0;
            end else begin
               oe_r[i]  <= pulse_nx;
               drv_r[i] <= pulse_nx & latch_val[i];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Outputs
   assign wb_ack_o                = ack_r;
   assign wb_dat_o                = dat_r;
   assign relay_update_strobe_n_o = strobe_n_r;
   assign drv_group_en_n_o        = grp_en_n_r;
   assign latch_drv_o             = drv_r;
   assign latch_drv_oe_o          = oe_r;
   assign held_relay_o            = held_r;
   assign control_latched_o       = latched_r;

   // ==========================================================
   // Checks
   logic [31:0] low_cnt_r;
   wire         lat_i_n = latched_r[F_I_N];
   wire         lat_o_n = latched_r[F_O_N];
   wire         volt_lat = lat_i_n & lat_o_n;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_cnt_r <= 32'h0;
      end else begin
         low_cnt_r <= strobe_n_r ? 32'h0 : low_cnt_r + 32'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_pulse_length: assert property ($rose(strobe_n_r) |-> low_cnt_r == P_PULSE_CYCLES)
      else $error("update pulse length wrong");
   chk_xfer_first: assert property ($fell(strobe_n_r) |-> $past(state_r, 2) == ST_XFER)
      else $error("strobe without prior transfer");
   chk_drive_window: assert property (|oe_r |-> !strobe_n_r)
      else $error("driver enabled outside strobe");
   chk_group_fanout: assert property (grp_en_n_r == {NGRP{strobe_n_r}})
      else $error("group enable differs from strobe");
   chk_iso_inverted: assert property (oe_r[DRV_ISO] && lat_o_n |-> !drv_r[DRV_ISO])
      else $error("isolation relay polarity wrong");
   chk_volt_relay: assert property (
      oe_r[DRV_VOLT] && lat_i_n && lat_o_n |-> drv_r[DRV_VOLT])
      else $error("voltage relay not selected");
   chk_refs_off: assert property (
      oe_r[DRV_DCREF] && lat_i_n |-> !drv_r[DRV_DCREF] && !drv_r[DRV_ACREF])
      else $error("current reference driven in non-current mode");
   chk_ohms_onehot: assert property (
      oe_r[DRV_OHM_LO] |-> $onehot0(drv_r[DRV_OHM_LO +: N_CODES]))
      else $error("ohms range select not one-hot");
   chk_cur_output: assert property (
      !strobe_n_r && $past(!strobe_n_r) |-> held_r[H_IOUT_A] == (!latched_r[F_OFF] && !lat_i_n))
      else $error("current output relay mismatch");
   chk_ohm_output: assert property (
      !strobe_n_r && $past(!strobe_n_r) |-> held_r[H_OOUT_A] ==
      (!latched_r[F_OFF] && !lat_o_n && !latched_r[F_WATCHDOG_A]))
      else $error("ohms output relay mismatch");
   chk_defer_cmd: assert property (
      go_req && busy |=> pend_r ##0 !strobe_n_r [*1] or (pend_r && strobe_n_r))
      else $error("command during update lost");

   // ==========================================================
   // Held relays, decode and sequencer, during the pulse and outside it
   // Held lines move only at pulse start; any other change would chatter contacts
   chk_latch_stable: assert property (
      state_r != ST_XFER |=> $stable(latched_r))
      else $error("latched word moved outside transfer");
   chk_held_stable: assert property (
      state_r != ST_SETTLE |=> $stable(held_r))
      else $error("held relay moved outside pulse start");
   chk_volt_ranges: assert property (
      !strobe_n_r && volt_lat |-> !held_r[H_R100M] && !held_r[H_R10M] && !held_r[H_R1M])
      else $error("current range relay set in voltage mode");
   chk_volt_filter: assert property (
      !strobe_n_r && volt_lat |-> held_r[H_FILT] && !drv_r[DRV_HIRNG])
      else $error("filter or high range relay wrong in voltage mode");
   chk_ac_lines: assert property (
      !strobe_n_r |-> held_r[H_ACIREF] == !lat_i_n &&
      held_r[H_ACV] == (volt_lat && !latched_r[F_AC_N]))
      else $error("ac line routing wrong");
   chk_func_exclusive: assert property (
      !strobe_n_r |-> $onehot0({drv_r[DRV_VOLT], held_r[H_IOUT_A], held_r[H_OOUT_A]}))
      else $error("more than one function relay selected");
   chk_pair_equal: assert property (
      held_r[H_IOUT_A] == held_r[H_IOUT_B] && held_r[H_OOUT_A] == held_r[H_OOUT_B])
      else $error("output relay pair split");
   chk_strobe_after: assert property (
      $fell(strobe_n_r) |-> $past(state_r) == ST_SETTLE && $stable(latched_r))
      else $error("strobe before control bits settled");
   chk_ohms_range: assert property (
      oe_r[DRV_OHM_LO] && !lat_o_n && !latched_r[F_ZERO]
      |-> drv_r[DRV_OHM_LO + latched_r[F_OR_LO +: CODE_W]])
      else $error("ohms range select does not follow code");
   chk_ref_select: assert property (
      oe_r[DRV_DCREF] && !lat_i_n && !latched_r[F_WATCHDOG_A]
      |-> drv_r[DRV_DCREF] == latched_r[F_DCI] && drv_r[DRV_ACREF] == !latched_r[F_DCI])
      else $error("current reference select wrong");
   chk_idle_quiet: assert property (
      strobe_n_r |-> drv_r == {NDRV{1'b0}})
      else $error("driver data outside strobe");
   chk_pend_serve: assert property (
      pend_r && !busy |=> state_r == ST_XFER)
      else $error("pending update not started");
   chk_zero_select: assert property (
      oe_r[DRV_ZERO] |-> drv_r[DRV_ZERO] == (latched_r[F_ZERO] || lat_o_n))
      else $error("ohms zero relay wrong");
   chk_spares_low: assert property (
      oe_r[DRV_SPARE0] |-> !drv_r[DRV_SPARE0] && !drv_r[DRV_SPARE1])
      else $error("spare driver selected");
   chk_cnt_range: assert property (
      !strobe_n_r |-> cnt_r <= CNT_LAST)
      else $error("pulse counter beyond last cycle");
   chk_xfer_quiet: assert property (
      state_r == ST_XFER |-> strobe_n_r && oe_r == {NDRV{1'b0}})
      else $error("drivers active during transfer");

   cov_update: cover property ($fell(strobe_n_r));
   cov_volt_update: cover property ($fell(strobe_n_r) && volt_lat);
   cov_deferred: cover property (go_req && state_r == ST_PULSE);
   cov_ohms_update: cover property ($fell(strobe_n_r) && !lat_o_n);
   cov_back_to_back: cover property ($rose(strobe_n_r) && pend_r);
endmodule

// ---- testbench/rudl_host_model.sv ----
// Wishbone master standing in for the instrument processor
`timescale 1ns/1ns
module rudl_host_model (
   input  wire logic        clk_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   input  wire logic        ack_i
);
   // ==========================================================
   // Idle bus
   initial begin
      {cyc_o, stb_o, we_o} = 3'h0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // ==========================================================
   // Classic single cycle
   // Held until ack is sampled; released address and data lines show inverted junk, not stale data
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                       input logic [31:0] wdat);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o} <= {2'b11, we};
      adr_o <= adr;
      sel_o <= sel;
      dat_o <= wdat;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      {cyc_o, stb_o, we_o} <= 3'h0;
      adr_o <= ~adr;
      dat_o <= ~wdat;
   endtask
endmodule

// ---- testbench/test_relay_update_drive_logic.sv ----
// Self-checking bench for the relay update drive logic
`timescale 1ns/1ns
module test_relay_update_drive_logic;
   import rudl_pkg::*;
   localparam int unsigned P = 20;
   logic        clk;
   logic        rst = 1'b1;
   logic        cyc, stb, we, ack, stb_n, prev_stb;
   logic [7:0]  adr;
   logic [3:0]  sel, grp_n;
   logic [31:0] wdat, rdat;
   logic [15:0] drv, oe, latched, c;
   logic [9:0]  held, held_last;
   logic [25:0] e;
   logic [31:0] rd_q[$];
   logic [25:0] up_q[$];
   logic [3:0]  fn_tab[5] = '{4'hE, 4'hA, 4'hB, 4'h3, 4'h9};
   int          miscompares = 0;
   int          total_checks = 0;
   int          cnt = 0;
   int          f;

   rudl_host_model i_rudl_host_model (.clk_i(clk), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat), .ack_i(ack));

   rudl_top #(.P_PULSE_CYCLES(P)) i_rudl_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .relay_update_strobe_n_o(stb_n),
      .drv_group_en_n_o(grp_n), .latch_drv_o(drv), .latch_drv_oe_o(oe),
      .held_relay_o(held), .control_latched_o(latched));

   // ==========================================================
   // Expected relay levels: {held, latching drivers}
   function automatic logic [25:0] expect_relays(input logic [15:0] c);
      logic        v;
      logic [7:0]  q;
      logic [15:0] d;
      logic [9:0]  h;
      v = c[F_I_N] & c[F_O_N];
      q = 8'h01 << (v ? IR_VOLT : c[F_IR_LO+:3]);
      d = 16'h0000;
      h = 10'h000;
      d[DRV_HIRNG] = q[Q_1A];
      d[DRV_VOLT] = v;
      d[DRV_ISO] = ~(c[F_O_N] | ~c[F_OR_LO+2] | c[F_ZERO] | (c[F_OR_LO+:3] == 3'h4));
      d[DRV_DCREF] = ~c[F_I_N] & ~c[F_WATCHDOG_A] & c[F_DCI];
      d[DRV_ACREF] = ~c[F_I_N] & ~c[F_WATCHDOG_A] & ~c[F_DCI];
      d[DRV_ZERO] = c[F_ZERO] | c[F_O_N];
      if (!c[F_ZERO] && !c[F_O_N]) d[DRV_OHM_LO+:8] = 8'h01 << c[F_OR_LO+:3];
      h[H_R100M] = q[Q_100M];
      h[H_R10M] = q[Q_10M];
      h[H_R1M] = q[Q_1M];
      h[H_FILT] = v | q[Q_100M] | q[Q_10M];
      h[H_IOUT_A] = ~c[F_OFF] & ~c[F_I_N];
      h[H_IOUT_B] = ~c[F_OFF] & ~c[F_I_N];
      h[H_OOUT_A] = ~c[F_O_N] & ~c[F_OFF] & ~c[F_WATCHDOG_A];
      h[H_OOUT_B] = ~c[F_O_N] & ~c[F_OFF] & ~c[F_WATCHDOG_A];
      h[H_ACV] = v & ~c[F_AC_N];
      h[H_ACIREF] = ~c[F_I_N];
      return {h, d};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      if (miscompares == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      i_rudl_host_model.xfer(1'b1, a, s, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      i_rudl_host_model.xfer(1'b0, a, 4'hF, 32'h0);
   endtask

   task automatic update(input logic [15:0] c);
      wr(ADR_CTRL, 4'h3, {16'h0, c});
      up_q.push_back(expect_relays(c));
      wr(ADR_CMD, 4'h1, 32'h1);
   endtask

   task automatic wait_idle;
      int i;
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         if (up_q.size() == 0 && stb_n === 1'b1) break;
      end
      if (i == 300) miscompares++;
   endtask

   // ==========================================================
   // Output watcher
   always @(posedge clk) begin
      if (!rst) begin
         check({28'h0, grp_n}, {28'h0, {4{stb_n}}}, "group enables");
         check({16'h0, oe}, stb_n ? 32'h0 : 32'h0000FFFF, "driver enables");
         if (stb_n) check({16'h0, drv}, 32'h0, "idle driver data");
         if (ack && !we) check(rdat, rd_q.size() ? rd_q.pop_front() : 'x, "read data");
         if (!stb_n && prev_stb) begin
            e = up_q.size() ? up_q.pop_front() : 'x;
            check({16'h0, drv}, {16'h0, e[15:0]}, "latching drivers");
            check({22'h0, held}, {22'h0, e[25:16]}, "held relays");
         end else begin
            check({22'h0, held}, {22'h0, held_last}, "held relays kept");
         end
         if (!stb_n) cnt++;
         if (stb_n && !prev_stb) begin
            check(32'(cnt), 32'(P), "pulse length");
            cnt = 0;
         end
      end
      prev_stb = stb_n;
      held_last = held;
   end

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Hang guard, far beyond the expected run
   initial begin
      #(40 * 20000);
      miscompares++;
      report_and_stop();
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(15));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({22'h0, held}, 32'h0, "held after reset");
      rd(ADR_CTRL, {16'h0, CTRL_RST});
      rd(ADR_LATCH, {16'h0, CTRL_RST});
      rd(ADR_STAT, 32'h0);
      rd(ADR_CMD, 32'h0);
      rd(8'h10, 32'h0);
      wr(ADR_STAT, 4'hF, 32'h3);
      rd(ADR_STAT, 32'h0);
      wr(ADR_CTRL, 4'hF, 32'h4215);
      wr(ADR_CTRL, 4'h1, 32'h0043);
      wr(ADR_CTRL, 4'hC, 32'hFFFFFFFF);
      rd(ADR_CTRL, 32'h4243);
      // Every function code once, then random ranges and flags
      for (int n = 0; n < 14; n++) begin
         f = (n < 5) ? n : $urandom_range(0, 4);
         c = {1'b0, 3'($urandom_range(0, 7)), 1'b0, 3'($urandom_range(0, 7)), 1'b0,
              1'($urandom), 1'(f > 1) & 1'($urandom), 1'(n >= 5) & 1'($urandom), fn_tab[f]};
         update(c);
         wait_idle();
         check({16'h0, latched}, {16'h0, c}, "latched word");
         rd(ADR_LATCH, {16'h0, c});
      end
      // Commands while busy merge into one deferred update with the newer word
      update(CTRL_RST);
      wr(ADR_CMD, 4'h1, 32'h1);
      wr(ADR_CTRL, 4'h3, 32'h2009);
      up_q.push_back(expect_relays(16'h2009));
      wr(ADR_CMD, 4'h1, 32'h1);
      rd(ADR_STAT, 32'h3);
      wait_idle();
      rd(ADR_STAT, 32'h0);
      rd(ADR_LATCH, 32'h2009);
      check({16'h0, latched}, 32'h2009, "latched word");
      check(32'(up_q.size()), 32'h0, "updates left");
      report_and_stop();
   end
endmodule
